// >>> hdl/hmpc_pkg.sv
/*
  Shared types and constants for the handshake mode-parameter composer.
  Assumes one 40 MHz clock domain; all users import the whole package.
*/
package hmpc_pkg;

  // Width of each level-3 value field
  localparam int unsigned HMPC_VAL_W = 8;

  // Clock figures, kept for reference by users of the block
  localparam int unsigned HMPC_CLK_HZ = 40_000_000;
  localparam int unsigned HMPC_CLK_PERIOD_NS = 25;

  // Cycles from a compose strobe to the message strobe
  localparam int unsigned HMPC_COMPOSE_LAT = 1;

  // Value after reset of a held value field
  localparam logic [HMPC_VAL_W-1:0] HMPC_VAL_RST = 8'h00;

  // Message kinds
  typedef enum logic [1:0] {
    HMPC_MSG_MS = 2'h1,
    HMPC_MSG_MP = 2'h2
  } hmpc_msg_kind_t;

  // Capability bits and values of one received CL or CLR message
  typedef struct packed {
    logic optional_band_upstream;
    logic optional_band_downstream;
    logic spectral_reduction;
    logic packet_transport_select;
    logic cell_transport_select;
    logic mgmt_channel_clear;
    logic ce_initial_sel;
    logic [HMPC_VAL_W-1:0] xform_size_val;
    logic [HMPC_VAL_W-1:0] ce_initial_val;
  } hmpc_caps_t;

  localparam hmpc_caps_t HMPC_CAPS_RST = '0;

  // Local wishes of the remote transceiver for the next message
  typedef struct packed {
    logic want_band_upstream;
    logic want_band_downstream;
    logic want_spectral_reduction;
    logic prefer_upstream;
    logic prefer_packet;
  } hmpc_wish_t;

  // Composed level-1/2/3 fields of one MS or MP message
  typedef struct packed {
    logic is_proposal;
    logic line_mode_sel;
    logic optional_band_upstream;
    logic optional_band_downstream;
    logic spectral_reduction;
    logic packet_transport_select;
    logic cell_transport_select;
    logic mgmt_channel_clear;
    logic used_bands_up_sel;
    logic used_bands_down_sel;
    logic xform_size_sel;
    logic ce_initial_sel;
    logic radio_interference_bands;
    logic xform_size_present;
    logic ce_initial_present;
    logic [HMPC_VAL_W-1:0] xform_size_val;
    logic [HMPC_VAL_W-1:0] ce_initial_val;
  } hmpc_msg_t;

  localparam hmpc_msg_t HMPC_MSG_RST = '0;

endpackage

// >>> hdl/hmpc_composer.sv
/*
  Composer of the level-1/2/3 parameter fields that the remote transceiver
  puts into its mode-select and mode-proposal handshake messages.
  Assumes capability loads and compose strobes come from logic on ref_clk_i;
  message transport and framing are handled elsewhere.
*/
//
// Function
// - Both used-band selection bits are always clear in MS and MP messages.
// - The transform-size bit is always set and carries the largest size both ends support.
// - The cyclic-extension bit is clear when either held CL or CLR had it clear.
// - The cyclic-extension bit is set only when both held messages had it set, with the length.
// - The very-high-speed line mode level-1 bit is asserted in every message.
// - Each set level-2 selection bit is accompanied by its level-3 value field.
// - In MP the optional-upstream-band bit proposes the low band for upstream use.
// - In MP the optional-downstream-band bit proposes the low band for downstream use.
// - An MP message never sets both optional-band bits.
// - In MP the spectral-reduction bit proposes reduced transmit PSD at low frequencies.
// - In MP packet and cell transport bits follow what both held messages allowed.
// - Exactly one of the packet and cell transport bits is set in an MP message when both share one; neither when none is common.
// - In MP the radio-interference-bands bit and both used-band bits are clear.
// - In MP the clear-management-channel bit is set only when both held messages had it.
// - In MS the band, transport and management bits need both held messages to have them.
`timescale 1ns/1ps

module hmpc_composer
  import hmpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Received capability messages
  input wire logic cl_load_i,
  input wire hmpc_caps_t cl_caps_i,
  input wire logic clr_load_i,
  input wire hmpc_caps_t clr_caps_i,
  // Compose request
  input wire logic compose_i,
  input wire hmpc_msg_kind_t compose_kind_i,
  input wire hmpc_wish_t wish_i,
  // Composed message
  output logic msg_valid_o,
  output hmpc_msg_t msg_o,
  output logic no_common_transport_o,
  output logic caps_complete_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [HMPC_VAL_W-1:0] val_min(
    input logic [HMPC_VAL_W-1:0] a,
    input logic [HMPC_VAL_W-1:0] b
  );
    val_min = (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Held capability copies

  hmpc_caps_t cl_caps_reg;
  hmpc_caps_t clr_caps_reg;
  logic cl_seen_reg;
  logic clr_seen_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cl_caps_reg <= HMPC_CAPS_RST;
      cl_seen_reg <= 1'b0;
    end else if (cl_load_i) begin
      cl_caps_reg <= cl_caps_i;
      cl_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clr_caps_reg <= HMPC_CAPS_RST;
      clr_seen_reg <= 1'b0;
    end else if (clr_load_i) begin
      clr_caps_reg <= clr_caps_i;
      clr_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common capabilities of both ends

  wire logic com_up = cl_caps_reg.optional_band_upstream & clr_caps_reg.optional_band_upstream;
  wire logic com_dn = cl_caps_reg.optional_band_downstream
                      & clr_caps_reg.optional_band_downstream;
  wire logic com_pkt = cl_caps_reg.packet_transport_select & clr_caps_reg.packet_transport_select;
  wire logic com_cell = cl_caps_reg.cell_transport_select & clr_caps_reg.cell_transport_select;
  wire logic com_mgmt = cl_caps_reg.mgmt_channel_clear & clr_caps_reg.mgmt_channel_clear;
  wire logic com_ce = cl_caps_reg.ce_initial_sel & clr_caps_reg.ce_initial_sel;
  wire logic is_mp = (compose_kind_i == HMPC_MSG_MP);

  ////////////////////////////////////////////////////////////////////////////
  // Band selection

  // MS picks from common bands; MP proposes the local wish
  wire logic band_up_cand = is_mp ? wish_i.want_band_upstream : com_up;
  wire logic band_dn_cand = is_mp ? wish_i.want_band_downstream : com_dn;
  // Both candidates: only one may go out, local preference decides
  wire logic band_both = band_up_cand & band_dn_cand;
  wire logic band_up_sel = band_both ? wish_i.prefer_upstream : band_up_cand;
  wire logic band_dn_sel = band_both ? !wish_i.prefer_upstream : band_dn_cand;

  ////////////////////////////////////////////////////////////////////////////
  // Transport selection

  // Both common: at most one bit may go out, so preference beats a plain copy
  wire logic pkt_sel = com_pkt & (!com_cell | wish_i.prefer_packet);
  wire logic cell_sel = com_cell & (!com_pkt | !wish_i.prefer_packet);
  wire logic no_transport = !com_pkt & !com_cell;

  // MS copies a reduction request from CL; MP proposes the local wish
  wire logic psd_sel = is_mp ? wish_i.want_spectral_reduction
                             : cl_caps_reg.spectral_reduction;

  ////////////////////////////////////////////////////////////////////////////
  // Message assembly

  hmpc_msg_t msg_next;

  always_comb begin
    msg_next = HMPC_MSG_RST;
    msg_next.is_proposal = is_mp;
    msg_next.line_mode_sel = 1'b1;
    msg_next.optional_band_upstream = band_up_sel;
    msg_next.optional_band_downstream = band_dn_sel;
    msg_next.spectral_reduction = psd_sel;
    msg_next.packet_transport_select = pkt_sel;
    msg_next.cell_transport_select = cell_sel;
    msg_next.mgmt_channel_clear = com_mgmt;
    msg_next.used_bands_up_sel = 1'b0;
    msg_next.used_bands_down_sel = 1'b0;
    msg_next.radio_interference_bands = 1'b0;
    msg_next.xform_size_sel = 1'b1;
    msg_next.xform_size_val = val_min(cl_caps_reg.xform_size_val,
                                      clr_caps_reg.xform_size_val);
    msg_next.ce_initial_sel = com_ce;
    // Length is the smaller held value when both allow extension; else HMPC_VAL_RST
    msg_next.ce_initial_val = com_ce ? val_min(cl_caps_reg.ce_initial_val,
                                               clr_caps_reg.ce_initial_val)
                                     : HMPC_VAL_RST;
    msg_next.xform_size_present = msg_next.xform_size_sel;
    msg_next.ce_initial_present = msg_next.ce_initial_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  hmpc_msg_t msg_reg;
  logic msg_valid_reg;
  logic no_transport_reg;
  logic caps_complete_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      msg_reg <= HMPC_MSG_RST;
      msg_valid_reg <= 1'b0;
      no_transport_reg <= 1'b0;
      caps_complete_reg <= 1'b0;
    end else begin
      msg_valid_reg <= compose_i;
      caps_complete_reg <= cl_seen_reg & clr_seen_reg;
      if (compose_i) begin
        msg_reg <= msg_next;
        no_transport_reg <= no_transport;
      end
    end
  end

  assign msg_o = msg_reg;
  assign msg_valid_o = msg_valid_reg;
  assign no_common_transport_o = no_transport_reg;
  assign caps_complete_o = caps_complete_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_compose_to_valid: assert property (
    compose_i |=> msg_valid_o ##1 (msg_valid_o == $past(compose_i))
  ) else $error("message strobe does not follow compose");

  a_used_bands_zero: assert property (
    msg_valid_o |-> !msg_o.used_bands_up_sel && !msg_o.used_bands_down_sel
  ) else $error("used-band bit set in message");

  a_xform_size_min: assert property (
    compose_i && !cl_load_i && !clr_load_i |=> msg_o.xform_size_sel
      && msg_o.xform_size_val == val_min(cl_caps_reg.xform_size_val,
                                         clr_caps_reg.xform_size_val)
  ) else $error("transform size not the common maximum");

  a_ce_cleared: assert property (
    compose_i && !(cl_caps_reg.ce_initial_sel && clr_caps_reg.ce_initial_sel)
      |=> !msg_o.ce_initial_sel && msg_o.ce_initial_val == HMPC_VAL_RST
  ) else $error("cyclic extension bit set without both capabilities");

  a_ce_set_length: assert property (
    compose_i && cl_caps_reg.ce_initial_sel && clr_caps_reg.ce_initial_sel
      && !cl_load_i && !clr_load_i
      |=> msg_o.ce_initial_sel
        && msg_o.ce_initial_val == val_min(cl_caps_reg.ce_initial_val,
                                           clr_caps_reg.ce_initial_val)
  ) else $error("cyclic extension bit or length wrong");

  a_mode_bit_set: assert property (
    msg_valid_o |-> msg_o.line_mode_sel
  ) else $error("line mode bit missing");

  a_level3_present: assert property (
    msg_valid_o |-> msg_o.xform_size_present == msg_o.xform_size_sel
      && msg_o.ce_initial_present == msg_o.ce_initial_sel
  ) else $error("level-3 field presence mismatch");

  a_mp_band_up: assert property (
    msg_valid_o && msg_o.is_proposal && msg_o.optional_band_upstream
      |-> $past(wish_i.want_band_upstream)
  ) else $error("upstream band proposed without wish");

  a_mp_band_down: assert property (
    msg_valid_o && msg_o.is_proposal && msg_o.optional_band_downstream
      |-> $past(wish_i.want_band_downstream)
  ) else $error("downstream band proposed without wish");

  a_band_exclusive: assert property (
    msg_valid_o |-> !(msg_o.optional_band_upstream && msg_o.optional_band_downstream)
  ) else $error("both optional bands set");

  a_mp_psd_wish: assert property (
    compose_i && is_mp |=> msg_o.spectral_reduction == $past(wish_i.want_spectral_reduction)
  ) else $error("spectral reduction proposal wrong");

  a_transport_common: assert property (
    compose_i && !cl_load_i && !clr_load_i
      |=> (!msg_o.packet_transport_select || $past(com_pkt))
        && (!msg_o.cell_transport_select || $past(com_cell))
  ) else $error("transport bit set without common capability");

  a_one_transport: assert property (
    msg_valid_o && !no_common_transport_o
      |-> msg_o.packet_transport_select ^ msg_o.cell_transport_select
  ) else $error("not exactly one transport bit");

  a_rfi_zero: assert property (
    msg_valid_o |-> !msg_o.radio_interference_bands
  ) else $error("interference bands bit set");

  a_mgmt_common: assert property (
    compose_i |=> msg_o.mgmt_channel_clear == $past(com_mgmt)
  ) else $error("management channel bit wrong");

  a_ms_band_common: assert property (
    compose_i && !is_mp
      |=> (!msg_o.optional_band_upstream || $past(com_up))
        && (!msg_o.optional_band_downstream || $past(com_dn))
  ) else $error("MS band bit without common capability");

  a_caps_held: assert property (
    !cl_load_i && !clr_load_i |=> $stable(cl_caps_reg) && $stable(clr_caps_reg)
  ) else $error("held capabilities changed without load");

  a_transport_sole: assert property (
    compose_i && (com_pkt != com_cell)
      |=> msg_o.packet_transport_select == $past(com_pkt)
        && msg_o.cell_transport_select == $past(com_cell)
  ) else $error("sole common transport not selected");

  a_no_transport_flag: assert property (
    msg_valid_o |-> no_common_transport_o
      == !(msg_o.packet_transport_select || msg_o.cell_transport_select)
  ) else $error("no-transport status disagrees with message");

  a_ms_band_sole: assert property (
    compose_i && !is_mp && (com_up != com_dn)
      |=> msg_o.optional_band_upstream == $past(com_up)
        && msg_o.optional_band_downstream == $past(com_dn)
  ) else $error("sole common band not selected");

  // Both bands possible: exactly one must survive the tie-break
  a_band_pick_one: assert property (
    compose_i && band_up_cand && band_dn_cand
      |=> msg_o.optional_band_upstream ^ msg_o.optional_band_downstream
  ) else $error("band tie-break left none or both");

  a_valid_after_compose: assert property (
    msg_valid_o |-> $past(compose_i)
  ) else $error("message strobe without compose");

  a_msg_held: assert property (
    !compose_i |=> $stable(msg_o) && $stable(no_common_transport_o)
  ) else $error("message changed without compose");

  a_caps_complete_hold: assert property (
    caps_complete_o |=> caps_complete_o
  ) else $error("capability status dropped without reset");

endmodule // hmpc_composer

// >>> verif/hmpc_office_model.sv
/*
  Behavioural model of the office-end handshake logic facing the composer.
  Assumes the bench asks for each capability message on ref_clk_i.
*/
`timescale 1ns/1ps

module hmpc_office_model
  import hmpc_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Request from the bench
  input wire logic send_i,
  input wire hmpc_caps_t caps_i,
  // Capability message toward the composer
  output logic cl_load_o,
  output hmpc_caps_t cl_caps_o,
  // Message back from the composer
  input wire logic msg_valid_i,
  input wire hmpc_msg_t msg_i,
  output logic ce_mandatory_o
);

  hmpc_caps_t last_reg;

  always_ff @(posedge ref_clk_i) begin
    if (send_i) begin
      last_reg <= caps_i;
    end
  end

  assign cl_load_o = send_i;
  // Released lines show the inverse, so stale caps never look fresh
  assign cl_caps_o = send_i ? caps_i : ~last_reg;

  // Fall back to the mandatory extension length when the bit is clear
  always_ff @(posedge ref_clk_i) begin
    if (msg_valid_i) begin
      ce_mandatory_o <= ~msg_i.ce_initial_sel;
    end
  end

endmodule // hmpc_office_model

// >>> verif/handshake_mode_param_composer_test.sv
/*
  Self-checking bench of the composer: corner cases, then seeded random traffic.
  Assumes the design package is compiled first.
*/
`timescale 1ns/1ps

module handshake_mode_param_composer_test;
  import hmpc_pkg::*;

  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cl_send = 1'b0, clr_load_i = 1'b0, compose_i = 1'b0;
  logic cl_load_i, msg_valid_o, no_common_transport_o, caps_complete_o, ce_mand, exp_none;
  hmpc_caps_t cl_want = '0, clr_caps_i = '0, cl_caps_i, exp_cl = '0, exp_clr = '0, c1, c2;
  hmpc_msg_kind_t compose_kind_i = HMPC_MSG_MS;
  hmpc_wish_t wish_i = '0;
  hmpc_msg_t msg_o, exp_msg;
  int n_fail = 0, checked = 0, seed = 96;
  logic [31:0] r;

  always #12.5 ref_clk_i = ~ref_clk_i;

  hmpc_composer dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cl_load_i(cl_load_i),
    .cl_caps_i(cl_caps_i), .clr_load_i(clr_load_i), .clr_caps_i(clr_caps_i),
    .compose_i(compose_i), .compose_kind_i(compose_kind_i), .wish_i(wish_i),
    .msg_valid_o(msg_valid_o), .msg_o(msg_o), .no_common_transport_o(no_common_transport_o),
    .caps_complete_o(caps_complete_o));

  hmpc_office_model office_u (.ref_clk_i(ref_clk_i), .send_i(cl_send), .caps_i(cl_want),
    .cl_load_o(cl_load_i), .cl_caps_o(cl_caps_i), .msg_valid_i(msg_valid_o),
    .msg_i(msg_o), .ce_mandatory_o(ce_mand));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, want);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic hmpc_msg_t expect_msg(input hmpc_caps_t a, input hmpc_caps_t b,
                                           input hmpc_msg_kind_t k, input hmpc_wish_t w);
    hmpc_msg_t m;
    logic mp, p, c, u, d;
    m = HMPC_MSG_RST;
    mp = (k == HMPC_MSG_MP);
    m.is_proposal = mp;
    m.line_mode_sel = 1'b1;
    m.xform_size_sel = 1'b1;
    m.xform_size_present = 1'b1;
    m.xform_size_val = min8(a.xform_size_val, b.xform_size_val);
    m.ce_initial_sel = a.ce_initial_sel & b.ce_initial_sel;
    m.ce_initial_present = m.ce_initial_sel;
    if (m.ce_initial_sel) m.ce_initial_val = min8(a.ce_initial_val, b.ce_initial_val);
    m.mgmt_channel_clear = a.mgmt_channel_clear & b.mgmt_channel_clear;
    p = a.packet_transport_select & b.packet_transport_select;
    c = a.cell_transport_select & b.cell_transport_select;
    if (p && c) begin
      p = w.prefer_packet;
      c = ~w.prefer_packet;
    end
    u = mp ? w.want_band_upstream : a.optional_band_upstream & b.optional_band_upstream;
    d = mp ? w.want_band_downstream : a.optional_band_downstream & b.optional_band_downstream;
    if (u && d) begin
      u = w.prefer_upstream;
      d = ~w.prefer_upstream;
    end
    m.packet_transport_select = p;
    m.cell_transport_select = c;
    m.optional_band_upstream = u;
    m.optional_band_downstream = d;
    m.spectral_reduction = mp ? w.want_spectral_reduction : a.spectral_reduction;
    return m;
  endfunction

  function automatic hmpc_caps_t rand_caps();
    logic [31:0] v;
    v = $random(seed);
    return v[$bits(hmpc_caps_t)-1:0];
  endfunction

  // CL and/or CLR load and/or compose, then the answer and the cycle after it
  task automatic step(input logic lc, input logic lr, input logic cp, input hmpc_caps_t a,
                      input hmpc_caps_t b, input hmpc_msg_kind_t k, input hmpc_wish_t w);
    @(posedge ref_clk_i);
    cl_send <= lc;
    clr_load_i <= lr;
    compose_i <= cp;
    cl_want <= a;
    clr_caps_i <= b;
    compose_kind_i <= k;
    wish_i <= w;
    if (cp) begin
      exp_msg = expect_msg(exp_cl, exp_clr, k, w);
      exp_none = !(exp_msg.packet_transport_select | exp_msg.cell_transport_select);
    end
    if (lc) exp_cl = a;
    if (lr) exp_clr = b;
    @(posedge ref_clk_i);
    cl_send <= 1'b0;
    clr_load_i <= 1'b0;
    compose_i <= 1'b0;
    #1;
    check(64'(msg_valid_o), 64'(cp), "message strobe");
    if (cp) begin
      check(64'(msg_o), 64'(exp_msg), "message fields");
      check(64'(no_common_transport_o), 64'(exp_none), "no common transport");
    end
    @(posedge ref_clk_i);
    #1;
    check(64'(msg_valid_o), 64'h0, "strobe length");
    if (cp) begin
      check(64'(msg_o), 64'(exp_msg), "message held");
      check(64'(ce_mand), 64'(!exp_msg.ce_initial_sel), "mandatory extension");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    step(1'b0, 1'b0, 1'b1, '0, '0, HMPC_MSG_MP, 5'h1F);
    check(64'(caps_complete_o), 64'h0, "no caps yet");
    c1 = rand_caps();
    c2 = rand_caps();
    step(1'b1, 1'b0, 1'b0, c1, '0, HMPC_MSG_MS, '0);
    check(64'(caps_complete_o), 64'h0, "only one caps");
    step(1'b0, 1'b1, 1'b1, c1, c2, HMPC_MSG_MS, '0);
    check(64'(caps_complete_o), 64'h1, "both caps");
    $display("Test load order done");
    step(1'b1, 1'b1, 1'b0, '1, '1, HMPC_MSG_MS, '0);
    for (int i = 0; i < 64; i++) begin
      r = i;
      step(1'b0, 1'b0, 1'b1, '0, '0, r[0] ? HMPC_MSG_MP : HMPC_MSG_MS, r[5:1]);
    end
    $display("Test kinds and wishes done");
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      c1 = rand_caps();
      c2 = rand_caps();
      step(r[0], r[1], r[2], c1, c2, r[3] ? HMPC_MSG_MP : HMPC_MSG_MS, r[8:4]);
    end
    $display("Test random traffic done");
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    exp_cl = '0;
    exp_clr = '0;
    #1;
    check(64'(caps_complete_o), 64'h0, "caps after reset");
    check(64'(msg_o), 64'(HMPC_MSG_RST), "message after reset");
    step(1'b0, 1'b0, 1'b1, '0, '0, HMPC_MSG_MS, 5'h1F);
    $display("Test second reset done");
    finish_test();
  end

  initial begin
    #(25 * 20000);
    n_fail++;
    finish_test();
  end

endmodule // handshake_mode_param_composer_test
